// *** rtl/pmc_pkg.sv ***
/*
  Shared constants and types of the run/margin command block of a bus-managed
  point-of-load converter. Assumes one 125 MHz core clock and a PMBus link
  sampled by that clock.
*/
// How it works
// - Enable field of the run byte counts only in bus enable mode.
// - Enable 00 switches the output off at once, no ramp.
// - Enable 01 turns off with a ramp timed by the fall time setting.
// - Enable 10 turns the output on at the margin-selected level.
// - Margin 00 nominal, 01 margin low, 10 margin high.
// - While margined, act field 01 ignores faults, 10 acts on them.
// - Power-up bit set keeps the output off until pin or bus enables.
// - Bus mode clear ignores the enable field; set requires it on.
// - Pin mode clear ignores the pin; set requires pin asserted.
// - Pin polarity bit: clear means low enables, set means high.
// - Pin turn-off: action bit clear soft off, set immediate off.
// - Clear-faults command resets every fault status bit.
// - Store-default saves the whole current configuration.
// - Restore-default reloads the whole configuration from default store.
// - Store-user saves values changed since the last restore.
// - Restore-user runs by itself at power-up, over default values.
// - After restore-user the security level becomes level one.
// - Output-voltage format byte is read-only.
// - Format low five bits hold a signed exponent.
// - Format top three bits: 000 linear, 001 VID, 010 direct.
package pmc_pkg;
  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_RUN_MARGIN = 8'h01;
  localparam logic [7:0] CMD_TURN_ON_SRC = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_DEFAULT = 8'h11;
  localparam logic [7:0] CMD_RESTORE_DEFAULT = 8'h12;
  localparam logic [7:0] CMD_STORE_USER = 8'h15;
  localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
  localparam logic [7:0] CMD_VOUT_FORMAT = 8'h20;
  localparam logic [7:0] RD_UNMAPPED = 8'hff;
  // ****************************************
  // Field values and reset values
  // ****************************************
  localparam logic [1:0] EN_IMMEDIATE_OFF = 2'h0;
  localparam logic [1:0] EN_SOFT_OFF = 2'h1;
  localparam logic [1:0] EN_ON = 2'h2;
  localparam logic [1:0] MG_NOMINAL = 2'h0;
  localparam logic [1:0] MG_LOW = 2'h1;
  localparam logic [1:0] MG_HIGH = 2'h2;
  localparam logic [1:0] ACT_IGNORE = 2'h1;
  localparam logic [1:0] ACT_RESPOND = 2'h2;
  localparam logic [1:0] FIELD_UNDEF = 2'h3;
  localparam int PWRUP_BIT = 4;
  localparam int BUS_MODE_BIT = 3;
  localparam int PIN_MODE_BIT = 2;
  localparam int PIN_POL_BIT = 1;
  localparam int DIS_ACT_BIT = 0;
  localparam logic [7:0] RUN_MARGIN_RST = 8'h88;
  localparam logic [7:0] TURN_ON_SRC_RST = 8'h1e;
  localparam logic [2:0] FMT_LINEAR = 3'h0;
  localparam logic [2:0] FMT_VID = 3'h1;
  localparam logic [2:0] FMT_DIRECT = 3'h2;
  localparam logic [4:0] FMT_EXP_RST = 5'h13;
  localparam logic [1:0] SEC_LEVEL_ONE = 2'h1;
  localparam logic [1:0] SEC_LEVEL_RST = 2'h0;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int USER_WAIT_MS = 20;
  localparam int USER_WAIT_CYC = USER_WAIT_MS * CLK_MHZ * 1000;
  localparam logic [6:0] BUS_ADDR_RST = 7'h20;

  typedef struct packed {
    logic [7:0] run_margin;
    logic [7:0] turn_on_src;
  } pmc_cfg_t;

  typedef struct packed {
    logic on;
    logic off_immediate;
    logic [1:0] margin;
    logic fault_respond;
  } pmc_out_t;
endpackage

// *** rtl/pmc_onoff_margin.sv ***
/*
  PMBus byte-command slave holding the run/margin and turn-on source bytes,
  their default and user stores, and the output on/off and margin decision.
  Assumes an SMBus master on scl/sda (open drain resolved outside) and a
  converter power stage that obeys the pmc_out_t outputs.
*/
`timescale 1ns/1ps
module pmc_onoff_margin #(
  parameter int USER_WAIT = pmc_pkg::USER_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic ctrl_pin_i,
  output pmc_pkg::pmc_out_t vout_ctl,
  output logic fault_clear,
  output logic store_busy,
  output logic [1:0] security_level,
  output pmc_pkg::pmc_cfg_t cfg_now
);
  import pmc_pkg::*;

  // ****************************************
  // Pin synchronisers and bus edge detection
  // ****************************************
  logic [2:0] scl_q, scl_d, sda_q, sda_d;
  logic [1:0] ctl_q, ctl_d;
  always_comb begin
    scl_d = {scl_q[1:0], scl_i};
    sda_d = {sda_q[1:0], sda_i};
    ctl_d = {ctl_q[0], ctrl_pin_i};
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      ctl_q <= 2'h0;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
      ctl_q <= ctl_d;
    end
  end
  // Bit 0 is the first stage; edges compare stages 1 and 2 only
  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire bus_start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  wire bus_stop = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

  // ****************************************
  // Byte-level SMBus slave
  // ****************************************
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_CMD, S_DATA, S_ACK, S_RD, S_RACK} pmc_bus_st_t;
  pmc_bus_st_t st_q, st_d, nxt_q, nxt_d;
  logic [7:0] sh_q, sh_d, cmd_q, cmd_d;
  logic [3:0] cnt_q, cnt_d;
  logic oe_q, oe_d, have_cmd_q, have_cmd_d, send_only_q, send_only_d;
  logic ev_send, ev_write;
  logic [7:0] rd_data;

  function automatic logic [7:0] read_byte(input logic [7:0] cmd, input pmc_cfg_t c);
    case (cmd)
      CMD_RUN_MARGIN: read_byte = c.run_margin;
      CMD_TURN_ON_SRC: read_byte = c.turn_on_src;
      CMD_VOUT_FORMAT: read_byte = {FMT_LINEAR, FMT_EXP_RST};
      default: read_byte = RD_UNMAPPED;
    endcase
  endfunction
  assign rd_data = read_byte(cmd_q, cfg_now);

  always_comb begin
    st_d = st_q;
    nxt_d = nxt_q;
    sh_d = sh_q;
    cmd_d = cmd_q;
    cnt_d = cnt_q;
    oe_d = oe_q;
    have_cmd_d = have_cmd_q;
    send_only_d = send_only_q;
    ev_send = 1'b0;
    ev_write = 1'b0;
    if (bus_start) begin
      st_d = S_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
      send_only_d = 1'b0;
    end else if (bus_stop) begin
      // A lone command byte closed by stop is a send-byte
      ev_send = send_only_q;
      st_d = S_IDLE;
      oe_d = 1'b0;
      send_only_d = 1'b0;
      have_cmd_d = 1'b0;
    end else begin
      case (st_q)
        S_ADDR, S_CMD, S_DATA: begin
          if (scl_rise && cnt_q < 4'h8) begin
            sh_d = {sh_q[6:0], sda_q[1]};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            oe_d = 1'b1;
            st_d = S_ACK;
            send_only_d = 1'b0;
            if (st_q == S_ADDR) begin
              if (sh_q[7:1] != BUS_ADDR_RST) begin
                oe_d = 1'b0;
                st_d = S_IDLE;
              end else if (sh_q[0]) begin
                nxt_d = have_cmd_q ? S_RD : S_IDLE;
              end else begin
                nxt_d = S_CMD;
              end
            end else if (st_q == S_CMD) begin
              cmd_d = sh_q;
              have_cmd_d = 1'b1;
              send_only_d = 1'b1;
              nxt_d = S_DATA;
            end else begin
              ev_write = 1'b1;
              nxt_d = S_IDLE;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            st_d = nxt_q;
            cnt_d = 4'h0;
            oe_d = 1'b0;
            if (nxt_q == S_RD) begin
              sh_d = {rd_data[6:0], 1'b0};
              oe_d = ~rd_data[7];
              cnt_d = 4'h1;
            end
          end
        end
        S_RD: begin
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              oe_d = 1'b0;
              st_d = S_RACK;
            end else begin
              oe_d = ~sh_q[7];
              sh_d = {sh_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        S_RACK: if (scl_fall) st_d = S_IDLE;
        default: st_d = S_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= S_IDLE;
      nxt_q <= S_IDLE;
      sh_q <= 8'h00;
      cmd_q <= 8'h00;
      cnt_q <= 4'h0;
      oe_q <= 1'b0;
      have_cmd_q <= 1'b0;
      send_only_q <= 1'b0;
    end else begin
      st_q <= st_d;
      nxt_q <= nxt_d;
      sh_q <= sh_d;
      cmd_q <= cmd_d;
      cnt_q <= cnt_d;
      oe_q <= oe_d;
      have_cmd_q <= have_cmd_d;
      send_only_q <= send_only_d;
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe = oe_q;

  // ****************************************
  // Configuration and its stores
  // ****************************************
  pmc_cfg_t cur_q, cur_d, dflt_q, dflt_d, user_q, user_d;
  logic [1:0] chg_q, chg_d, uvld_q, uvld_d;
  logic init_q, fclr_q, fclr_d;
  logic [1:0] sec_q, sec_d;
  logic [31:0] wait_q, wait_d;
  logic do_ruser;
  // Power-up restore runs one cycle after reset release
  assign do_ruser = init_q | (ev_send && cmd_q == CMD_RESTORE_USER);
  always_comb begin
    cur_d = cur_q;
    dflt_d = dflt_q;
    user_d = user_q;
    chg_d = chg_q;
    uvld_d = uvld_q;
    sec_d = sec_q;
    fclr_d = 1'b0;
    wait_d = (wait_q != 32'h0) ? wait_q - 32'h1 : wait_q;
    // Format byte has no write path at all
    if (ev_write && cmd_q == CMD_RUN_MARGIN) begin
      cur_d.run_margin = sh_q;
      chg_d[1] = 1'b1;
    end
    if (ev_write && cmd_q == CMD_TURN_ON_SRC) begin
      cur_d.turn_on_src = sh_q;
      chg_d[0] = 1'b1;
    end
    if (ev_send && cmd_q == CMD_CLEAR_FAULTS) fclr_d = 1'b1;
    if (ev_send && cmd_q == CMD_STORE_DEFAULT) dflt_d = cur_q;
    if (ev_send && cmd_q == CMD_RESTORE_DEFAULT) begin
      cur_d = dflt_q;
      chg_d = 2'h0;
    end
    if (ev_send && cmd_q == CMD_STORE_USER) begin
      if (chg_q[1]) user_d.run_margin = cur_q.run_margin;
      if (chg_q[0]) user_d.turn_on_src = cur_q.turn_on_src;
      uvld_d = uvld_q | chg_q;
      wait_d = 32'(USER_WAIT);
    end
    if (do_ruser) begin
      if (uvld_q[1]) cur_d.run_margin = user_q.run_margin;
      if (uvld_q[0]) cur_d.turn_on_src = user_q.turn_on_src;
      chg_d = 2'h0;
      sec_d = SEC_LEVEL_ONE;
      wait_d = 32'(USER_WAIT);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur_q <= '{run_margin: RUN_MARGIN_RST, turn_on_src: TURN_ON_SRC_RST};
      dflt_q <= '{run_margin: RUN_MARGIN_RST, turn_on_src: TURN_ON_SRC_RST};
      user_q <= '{run_margin: RUN_MARGIN_RST, turn_on_src: TURN_ON_SRC_RST};
      chg_q <= 2'h0;
      uvld_q <= 2'h0;
      init_q <= 1'b1;
      sec_q <= SEC_LEVEL_RST;
      fclr_q <= 1'b0;
      wait_q <= 32'h0;
    end else begin
      cur_q <= cur_d;
      dflt_q <= dflt_d;
      user_q <= user_d;
      chg_q <= chg_d;
      uvld_q <= uvld_d;
      init_q <= 1'b0;
      sec_q <= sec_d;
      fclr_q <= fclr_d;
      wait_q <= wait_d;
    end
  end
  assign cfg_now = cur_q;
  assign fault_clear = fclr_q;
  assign store_busy = wait_q != 32'h0;
  assign security_level = sec_q;

  // ****************************************
  // Run decision
  // ****************************************
  logic [1:0] en_q, en_d, mg_q, mg_d, act_q, act_d;
  pmc_out_t out_q, out_d;
  logic bus_mode, pin_mode, pin_ok, bus_ok, run;
  wire [7:0] src = cur_q.turn_on_src;
  wire [7:0] op = cur_q.run_margin;
  always_comb begin
    // Undefined codes keep the last defined one
    en_d = (op[7:6] != FIELD_UNDEF) ? op[7:6] : en_q;
    mg_d = (op[5:4] != FIELD_UNDEF) ? op[5:4] : mg_q;
    act_d = (op[3:2] == ACT_IGNORE || op[3:2] == ACT_RESPOND) ? op[3:2] : act_q;
    bus_mode = src[BUS_MODE_BIT];
    pin_mode = src[PIN_MODE_BIT];
    pin_ok = ~pin_mode | (ctl_q[1] == src[PIN_POL_BIT]);
    bus_ok = ~bus_mode | (en_q == EN_ON);
    // With neither source in use the power-up bit alone holds it off
    run = bus_ok & pin_ok & (bus_mode | pin_mode | ~src[PWRUP_BIT]);
    out_d = out_q;
    out_d.on = run;
    out_d.margin = mg_q;
    out_d.fault_respond = (mg_q == MG_NOMINAL) | (act_q == ACT_RESPOND);
    if (!run) begin
      out_d.off_immediate = (bus_mode & en_q == EN_IMMEDIATE_OFF)
                          | (~pin_ok & src[DIS_ACT_BIT]);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      en_q <= EN_SOFT_OFF;
      mg_q <= MG_NOMINAL;
      act_q <= ACT_RESPOND;
      out_q <= '{on: 1'b0, off_immediate: 1'b0, margin: MG_NOMINAL, fault_respond: 1'b1};
    end else begin
      en_q <= en_d;
      mg_q <= mg_d;
      act_q <= act_d;
      out_q <= out_d;
    end
  end
  assign vout_ctl = out_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_clear_cmd;
    ev_send && cmd_q == CMD_CLEAR_FAULTS;
  endsequence
  property p_clear;
    @(posedge clk) disable iff (!rst_b) s_clear_cmd |=> fault_clear ##1 !fault_clear;
  endproperty
  a_clear: assert property (p_clear) else $error("clear pulse wrong");
  property p_bus_off;
    @(posedge clk) disable iff (!rst_b) (bus_mode && en_q != EN_ON) |=> !vout_ctl.on;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("on without bus enable");
  property p_imm;
    @(posedge clk) disable iff (!rst_b)
      (bus_mode && en_q == EN_IMMEDIATE_OFF && !(~pin_ok & src[DIS_ACT_BIT]) && pin_ok) |=> vout_ctl.off_immediate;
  endproperty
  a_imm: assert property (p_imm) else $error("bus off not immediate");
  property p_soft;
    @(posedge clk) disable iff (!rst_b) (bus_mode && en_q == EN_SOFT_OFF && pin_ok) |=> !vout_ctl.off_immediate;
  endproperty
  a_soft: assert property (p_soft) else $error("soft off became immediate");
  property p_pin;
    @(posedge clk) disable iff (!rst_b) (pin_mode && ctl_q[1] != src[PIN_POL_BIT]) |=> !vout_ctl.on;
  endproperty
  a_pin: assert property (p_pin) else $error("on with pin deasserted");
  property p_sec;
    @(posedge clk) disable iff (!rst_b) do_ruser |=> security_level == SEC_LEVEL_ONE && store_busy;
  endproperty
  a_sec: assert property (p_sec) else $error("restore-user effects missing");
  property p_rdflt;
    @(posedge clk) disable iff (!rst_b)
      (ev_send && cmd_q == CMD_RESTORE_DEFAULT && !init_q) |=> cfg_now == $past(dflt_q) && chg_q == 2'h0;
  endproperty
  a_rdflt: assert property (p_rdflt) else $error("default restore wrong");
  property p_undef;
    @(posedge clk) disable iff (!rst_b) (op[5:4] == FIELD_UNDEF) |=> $stable(mg_q);
  endproperty
  a_undef: assert property (p_undef) else $error("undefined margin changed");
  property p_ro;
    @(posedge clk) disable iff (!rst_b) (ev_write && cmd_q == CMD_VOUT_FORMAT) |=> $stable(cfg_now);
  endproperty
  a_ro: assert property (p_ro) else $error("format write changed config");
endmodule

// *** sim/pmc_host_model.sv ***
/*
  Host side of the PMBus link: bit-banged byte transfers, 20 core clocks per
  link clock (160 ns). Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/1ps
module pmc_host_model #(
  parameter int WAIT_CYC = 50,
  parameter logic [6:0] ADDR = 7'h20
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // ****
  // Link primitives
  // ****
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves only mid-low, never near an edge of the link clock
  task automatic bit_io(input logic b, output logic r);
    sda_pull <= !b;
    q(5);
    scl <= 1'b1;
    q(5);
    r = sda_line;
    q(5);
    scl <= 1'b0;
    q(5);
  endtask
  task automatic start_c;
    sda_pull <= 1'b0;
    q(5);
    scl <= 1'b1;
    q(5);
    sda_pull <= 1'b1;
    q(5);
    scl <= 1'b0;
    q(5);
  endtask
  task automatic stop_c;
    sda_pull <= 1'b1;
    q(5);
    scl <= 1'b1;
    q(5);
    sda_pull <= 1'b0;
    q(10);
  endtask
  // Acknowledge slot always released: reads end with a NACK
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(1'b1, b);
    ack = !b;
  endtask
  // ****
  // Transactions
  // ****
  task automatic write_cmd(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input bit has_d,
                           output bit ok);
    logic [7:0] r;
    logic k1;
    logic k2;
    logic k3;
    start_c;
    byte_io({a, 1'b0}, r, k1);
    byte_io(c, r, k2);
    k3 = 1'b1;
    if (has_d) begin
      byte_io(d, r, k3);
    end
    stop_c;
    ok = k1 && k2 && k3;
    if (!has_d && (c == 8'h15 || c == 8'h16)) begin
      q(WAIT_CYC + 10);
    end
  endtask
  task automatic read_cmd(input logic [7:0] c, output logic [7:0] d, output bit ok);
    logic [7:0] r;
    logic k1;
    logic k2;
    logic k3;
    start_c;
    byte_io({ADDR, 1'b0}, r, k1);
    byte_io(c, r, k2);
    start_c;
    byte_io({ADDR, 1'b1}, r, k3);
    byte_io(8'hff, d, k3);
    stop_c;
    ok = k1 && k2;
  endtask
endmodule

// *** sim/tb_top.sv ***
/*
  Bench for the run/margin block: a table of source/run/pin cases, then
  hand tests. Assumes the host model and a pulled-up data line.
*/
`timescale 1ns/1ps
module tb_top;
  import pmc_pkg::*;
  localparam int WAITC = 50;
  // Flags: pin, on, off_immediate, margin[1:0], fault_respond
  typedef struct packed {
    logic [7:0] src;
    logic [7:0] run;
    logic [5:0] f;
  } pmc_row_t;
  logic clk;
  logic rst_b;
  logic ctrl_pin_i;
  logic scl;
  logic sda_pull;
  logic sda_oe;
  logic fault_clear;
  logic store_busy;
  logic [1:0] security_level;
  pmc_out_t vout_ctl;
  pmc_cfg_t cfg_now;
  wire logic sda_line;
  int n_fail;
  int total_checks;
  int busy_cyc;
  int fc_cyc;
  logic [7:0] rd;
  bit ok;
  pmc_row_t rows [17] = '{{8'h1e, 8'h80, 6'h31}, {8'h1e, 8'h94, 6'h32}, {8'h1e, 8'ha8, 6'h35},
    {8'h1e, 8'ha4, 6'h34}, {8'h1e, 8'h40, 6'h21}, {8'h1e, 8'h00, 6'h29}, {8'h16, 8'h00, 6'h31},
    {8'h16, 8'h00, 6'h01}, {8'h14, 8'h00, 6'h11}, {8'h14, 8'h00, 6'h21}, {8'h15, 8'h00, 6'h11},
    {8'h15, 8'h00, 6'h29}, {8'h1a, 8'h80, 6'h11}, {8'h1a, 8'h98, 6'h13}, {8'h1a, 8'hf4, 6'h12},
    {8'h10, 8'h80, 6'h21}, {8'h02, 8'h00, 6'h11}};
  // Released line floats high through the pull-up
  assign sda_line = !(sda_pull || sda_oe === 1'b1);
  pmc_onoff_margin #(.USER_WAIT(WAITC)) u_dut (.clk(clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda_line),
    .sda_o(), .sda_oe(sda_oe), .ctrl_pin_i(ctrl_pin_i), .vout_ctl(vout_ctl), .fault_clear(fault_clear),
    .store_busy(store_busy), .security_level(security_level), .cfg_now(cfg_now));
  pmc_host_model #(.WAIT_CYC(WAITC), .ADDR(BUS_ADDR_RST)) u_host (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_pull(sda_pull));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (store_busy === 1'b1) busy_cyc++;
    if (fault_clear === 1'b1) fc_cyc++;
  end
  // ****
  // Checking and control
  // ****
  task automatic chk_bit(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk_vec(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input bit has_d);
    u_host.write_cmd(BUS_ADDR_RST, c, d, has_d, ok);
    chk_bit("ack", 1'b1, ok);
  endtask
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk_vec("cfg_reset", {RUN_MARGIN_RST, TURN_ON_SRC_RST}, cfg_now);
    chk_vec("sec_reset", {14'h0, SEC_LEVEL_RST}, {14'h0, security_level});
    chk_bit("on_reset", 1'b0, vout_ctl.on);
    for (int i = 0; i < 5 && security_level !== SEC_LEVEL_ONE; i++) @(posedge clk);
    #1;
    chk_vec("sec_powerup", {14'h0, SEC_LEVEL_ONE}, {14'h0, security_level});
    chk_bit("busy_powerup", 1'b1, store_busy);
    // Host may not talk before the power-up restore finishes
    for (int i = 0; i < WAITC + 50 && store_busy !== 1'b0; i++) @(posedge clk);
    if (store_busy !== 1'b0) begin
      n_fail++;
      stop_test;
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    n_fail = 0;
    total_checks = 0;
    busy_cyc = 0;
    fc_cyc = 0;
    rst_b = 1'b0;
    ctrl_pin_i = 1'b1;
    do_reset;
    foreach (rows[i]) begin
      wr(CMD_TURN_ON_SRC, rows[i].src, 1'b1);
      wr(CMD_RUN_MARGIN, rows[i].run, 1'b1);
      ctrl_pin_i <= rows[i].f[5];
      repeat (10) @(posedge clk);
      #1;
      chk_vec("cfg", {rows[i].run, rows[i].src}, cfg_now);
      chk_bit("on", rows[i].f[4], vout_ctl.on);
      chk_vec("margin", {14'h0, rows[i].f[2:1]}, {14'h0, vout_ctl.margin});
      chk_bit("fault_respond", rows[i].f[0], vout_ctl.fault_respond);
      if (!rows[i].f[4]) chk_bit("off_immediate", rows[i].f[3], vout_ctl.off_immediate);
    end
    u_host.read_cmd(CMD_VOUT_FORMAT, rd, ok);
    chk_vec("format", {8'h0, FMT_LINEAR, FMT_EXP_RST}, {8'h0, rd});
    wr(CMD_VOUT_FORMAT, 8'h00, 1'b1);
    u_host.read_cmd(CMD_VOUT_FORMAT, rd, ok);
    chk_vec("format_ro", 16'h0013, {8'h0, rd});
    u_host.read_cmd(8'h7f, rd, ok);
    chk_vec("unmapped", 16'h00ff, {8'h0, rd});
    u_host.write_cmd(7'h21, CMD_RUN_MARGIN, 8'h94, 1'b1, ok);
    chk_bit("foreign_ack", 1'b0, ok);
    fc_cyc = 0;
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b0);
    chk_vec("fault_clear", 16'h0001, fc_cyc[15:0]);
    wr(CMD_RUN_MARGIN, 8'h94, 1'b1);
    wr(CMD_STORE_DEFAULT, 8'h00, 1'b0);
    wr(CMD_RUN_MARGIN, 8'ha8, 1'b1);
    wr(CMD_RESTORE_DEFAULT, 8'h00, 1'b0);
    chk_vec("cfg_default", 16'h9402, cfg_now);
    busy_cyc = 0;
    wr(CMD_RESTORE_USER, 8'h00, 1'b0);
    chk_bit("busy_len", 1'b1, busy_cyc >= WAITC && busy_cyc <= WAITC + 2);
    chk_vec("sec_user", {14'h0, SEC_LEVEL_ONE}, {14'h0, security_level});
    wr(CMD_RUN_MARGIN, 8'h98, 1'b1);
    wr(CMD_STORE_USER, 8'h00, 1'b0);
    wr(CMD_RUN_MARGIN, 8'h40, 1'b1);
    wr(CMD_TURN_ON_SRC, 8'h1e, 1'b1);
    wr(CMD_RESTORE_USER, 8'h00, 1'b0);
    chk_vec("cfg_user", 16'h981e, cfg_now);
    do_reset;
    stop_test;
  end
endmodule
